/* hrw_pkg.sv */
// Shared constants and carrier types for the host register write port.
// Assumes a single 250 MHz core clock; all host pins are asynchronous.
package hrw_pkg;

   // -------------------------------------------------------------------
   // Widths and counts
   // -------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_REGS = 256;
   localparam int SYNC_STAGES = 2;

   // -------------------------------------------------------------------
   // Values after reset
   // -------------------------------------------------------------------
   localparam logic [DATA_W-1:0] REG_RST_VAL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST_VAL = 8'h00;
   localparam logic [1:0] RST_SYNC_RST_VAL = 2'h0;

   // -------------------------------------------------------------------
   // Carrier types
   // -------------------------------------------------------------------
   // Host pin group as seen at the device; strobes are active low
   typedef struct packed {
      logic write_strobe_low;
      logic read_strobe_low;
      logic chip_select_low;
      logic ale;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hrw_pins_t;

   // Idle pin levels, used as the synchroniser reset value
   localparam hrw_pins_t PINS_IDLE = '{
      write_strobe_low: 1'b1,
      read_strobe_low: 1'b1,
      chip_select_low: 1'b1,
      ale: 1'b1,
      addr: 8'h00,
      data: 8'h00
   };

   // Write event handed to the core logic
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hrw_wr_t;

endpackage

/* hrw_regfile.sv */
// Register array behind the host port, with one write and two read ports.
// Assumes the caller supplies a decoded write strobe in the core clock.
`timescale 1ns/1ps
module hrw_regfile #(
   parameter int NREGS = hrw_pkg::NUM_REGS
) (
   input wire logic clk_i,
   input wire logic arst_low_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [hrw_pkg::ADDR_W-1:0] waddr_i,
   input wire logic [hrw_pkg::DATA_W-1:0] wdata_i,
   input wire logic [hrw_pkg::ADDR_W-1:0] raddr_a_i,
   output logic [hrw_pkg::DATA_W-1:0] rdata_a_o,
   input wire logic [hrw_pkg::ADDR_W-1:0] raddr_b_i,
   output logic [hrw_pkg::DATA_W-1:0] rdata_b_o
);

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   logic [hrw_pkg::DATA_W-1:0] mem_r [NREGS];
   logic [hrw_pkg::DATA_W-1:0] mem_nxt [NREGS];

   // One-hot select of a single register from the address
   function automatic logic sel(input logic [hrw_pkg::ADDR_W-1:0] a,
                                input int idx);
      sel = (int'(a) == idx);
   endfunction

   always_comb begin
      for (int i = 0; i < NREGS; i++) begin
         mem_nxt[i] = mem_r[i];
         if (we_i && sel(waddr_i, i)) begin
            mem_nxt[i] = wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_low_i) begin
      if (!arst_low_i) begin
         for (int i = 0; i < NREGS; i++) begin
            mem_r[i] <= hrw_pkg::REG_RST_VAL;
         end
      end else if (srst_i) begin
         for (int i = 0; i < NREGS; i++) begin
            mem_r[i] <= hrw_pkg::REG_RST_VAL;
         end
      end else if (ce_i) begin
         for (int i = 0; i < NREGS; i++) begin
            mem_r[i] <= mem_nxt[i];
         end
      end
   end

   // -------------------------------------------------------------------
   // Read ports
   // -------------------------------------------------------------------
   always_comb begin
      rdata_a_o = hrw_pkg::REG_RST_VAL;
      rdata_b_o = hrw_pkg::REG_RST_VAL;
      for (int i = 0; i < NREGS; i++) begin
         if (sel(raddr_a_i, i)) begin
            rdata_a_o = mem_r[i];
         end
         if (sel(raddr_b_i, i)) begin
            rdata_b_o = mem_r[i];
         end
      end
   end

endmodule

/* hrw_port.sv */
// Host register port: address latch, write capture, read drive, reset.
// Assumes asynchronous host pins and a 250 MHz core clock on clk_i.
`timescale 1ns/1ps
module hrw_port #(
   parameter int NREGS = hrw_pkg::NUM_REGS
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic async_reset_low_i,
   input wire hrw_pkg::hrw_pins_t pins_i,
   output logic [hrw_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic [hrw_pkg::ADDR_W-1:0] user_addr_i,
   output logic [hrw_pkg::DATA_W-1:0] user_data_o,
   output hrw_pkg::hrw_wr_t wr_evt_o,
   output logic in_reset_o,
   output logic cs_released_o
);

   // -------------------------------------------------------------------
   // Reset: asserted at once by the pin, released in step with clk_i
   // -------------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic [1:0] rst_sync_nxt;
   logic in_reset_r;
   logic in_reset_nxt;
   logic rst_any;

   // Release waits two edges so no flop leaves reset on a late edge
   always_comb begin
      rst_sync_nxt = {rst_sync_r[0], 1'b1};
      // Registered copy of the held state for the status output
      in_reset_nxt = ~rst_sync_nxt[1];
   end

   always_ff @(posedge clk_i or negedge async_reset_low_i) begin
      if (!async_reset_low_i) begin
         rst_sync_r <= hrw_pkg::RST_SYNC_RST_VAL;
         in_reset_r <= 1'b1;
      end else if (ce_i) begin
         rst_sync_r <= rst_sync_nxt;
         in_reset_r <= in_reset_nxt;
      end
   end

   assign rst_any = srst_i | ~rst_sync_r[1];

   // -------------------------------------------------------------------
   // Pin synchroniser
   // -------------------------------------------------------------------
   hrw_pkg::hrw_pins_t sync1_r;
   hrw_pkg::hrw_pins_t sync2_r;
   hrw_pkg::hrw_pins_t sync1_nxt;
   hrw_pkg::hrw_pins_t sync2_nxt;

   // Two flops ahead of any logic; every host pin is asynchronous
   always_comb begin
      sync1_nxt = pins_i;
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge clk_i or negedge async_reset_low_i) begin
      if (!async_reset_low_i) begin
         sync1_r <= hrw_pkg::PINS_IDLE;
         sync2_r <= hrw_pkg::PINS_IDLE;
      end else if (rst_any) begin
         sync1_r <= hrw_pkg::PINS_IDLE;
         sync2_r <= hrw_pkg::PINS_IDLE;
      end else if (ce_i) begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Chip select release, counted only from real pin samples
   // -------------------------------------------------------------------
   logic [1:0] fill_r;
   logic [1:0] fill_nxt;
   logic cs_rel_r;
   logic cs_rel_nxt;

   always_comb begin
      // Synchroniser reset value is no pin sample; wait two loads
      fill_nxt = {fill_r[0], 1'b1};
      cs_rel_nxt = cs_rel_r |
                   (fill_r[1] & sync2_r.chip_select_low);
   end

   always_ff @(posedge clk_i or negedge async_reset_low_i) begin
      if (!async_reset_low_i) begin
         fill_r <= '0;
         cs_rel_r <= 1'b0;
      end else if (rst_any) begin
         fill_r <= '0;
         cs_rel_r <= 1'b0;
      end else if (ce_i) begin
         fill_r <= fill_nxt;
         cs_rel_r <= cs_rel_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Address latch, write edge detect, read drive
   // -------------------------------------------------------------------
   logic [hrw_pkg::ADDR_W-1:0] addr_lat_r;
   logic [hrw_pkg::ADDR_W-1:0] addr_lat_nxt;
   logic wr_or_r;
   logic wr_or_nxt;
   hrw_pkg::hrw_wr_t wr_evt_r;
   hrw_pkg::hrw_wr_t wr_evt_nxt;
   logic [hrw_pkg::DATA_W-1:0] data_r;
   logic [hrw_pkg::DATA_W-1:0] data_nxt;
   logic data_oe_r;
   logic data_oe_nxt;
   logic [hrw_pkg::DATA_W-1:0] user_data_r;
   logic [hrw_pkg::DATA_W-1:0] user_data_nxt;
   logic [hrw_pkg::ADDR_W-1:0] cur_addr;
   logic [hrw_pkg::DATA_W-1:0] host_rdata;
   logic [hrw_pkg::DATA_W-1:0] user_rdata;
   logic wr_or_now;
   logic wr_rise;

   always_comb begin
      // Transparent when enable high, held when low
      if (sync2_r.ale) begin
         cur_addr = sync2_r.addr;
      end else begin
         cur_addr = addr_lat_r;
      end
      addr_lat_nxt = cur_addr;

      // Write completes when either strobe or select rises first
      wr_or_now = sync2_r.write_strobe_low | sync2_r.chip_select_low;
      wr_or_nxt = wr_or_now;
      wr_rise = wr_or_now & ~wr_or_r;

      wr_evt_nxt.valid = wr_rise;
      wr_evt_nxt.addr = cur_addr;
      wr_evt_nxt.data = sync2_r.data;

      // Drive only while both read strobe and chip select are low
      data_oe_nxt = ~sync2_r.read_strobe_low &
                    ~sync2_r.chip_select_low;
      data_nxt = data_oe_nxt ? host_rdata : hrw_pkg::REG_RST_VAL;

      user_data_nxt = user_rdata;
   end

   always_ff @(posedge clk_i or negedge async_reset_low_i) begin
      if (!async_reset_low_i) begin
         addr_lat_r <= hrw_pkg::ADDR_RST_VAL;
         wr_or_r <= 1'b1;
         wr_evt_r <= '0;
         data_r <= hrw_pkg::REG_RST_VAL;
         data_oe_r <= 1'b0;
         user_data_r <= hrw_pkg::REG_RST_VAL;
      end else if (rst_any) begin
         addr_lat_r <= hrw_pkg::ADDR_RST_VAL;
         wr_or_r <= 1'b1;
         wr_evt_r <= '0;
         data_r <= hrw_pkg::REG_RST_VAL;
         data_oe_r <= 1'b0;
         user_data_r <= hrw_pkg::REG_RST_VAL;
      end else if (ce_i) begin
         addr_lat_r <= addr_lat_nxt;
         wr_or_r <= wr_or_nxt;
         wr_evt_r <= wr_evt_nxt;
         data_r <= data_nxt;
         data_oe_r <= data_oe_nxt;
         user_data_r <= user_data_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Register array
   // -------------------------------------------------------------------
   hrw_regfile #(
      .NREGS(NREGS)
   ) u_regfile (
      .clk_i(clk_i),
      .arst_low_i(async_reset_low_i),
      .srst_i(rst_any),
      .ce_i(ce_i),
      .we_i(wr_rise),
      .waddr_i(cur_addr),
      .wdata_i(sync2_r.data),
      .raddr_a_i(cur_addr),
      .rdata_a_o(host_rdata),
      .raddr_b_i(user_addr_i),
      .rdata_b_o(user_rdata)
   );

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign data_o = data_r;
   assign data_oe_o = data_oe_r;
   assign user_data_o = user_data_r;
   assign wr_evt_o = wr_evt_r;
   assign in_reset_o = in_reset_r;
   assign cs_released_o = cs_rel_r;

endmodule

/* hrw_port_checker.sv */
// Timing checks on the host register port, seen at its top ports.
// Assumes host pins change only just after rising clock edges.
`timescale 1ns/1ps
module hrw_port_checker #(
   parameter int NREGS = hrw_pkg::NUM_REGS
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic async_reset_low_i,
   input wire hrw_pkg::hrw_pins_t pins_i,
   input wire logic [7:0] data_o,
   input wire logic data_oe_o,
   input wire logic [7:0] user_addr_i,
   input wire logic [7:0] user_data_o,
   input wire hrw_pkg::hrw_wr_t wr_evt_o,
   input wire logic in_reset_o,
   input wire logic cs_released_o
);
   wire logic wor_s = pins_i.write_strobe_low | pins_i.chip_select_low;
   wire logic rd_s = !pins_i.read_strobe_low && !pins_i.chip_select_low;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i || in_reset_o);
   chk_wr_cause: assert property (
      wr_evt_o.valid |-> $past(wor_s, 3) && !$past(wor_s, 4))
      else $error("write event without strobe rise");
   chk_wr_fires: assert property (
      $past(wor_s, 3) && !$past(wor_s, 4) && $past(pins_i.addr, 3) < NREGS
      |-> wr_evt_o.valid) else $error("strobe rise gave no write");
   chk_wr_data: assert property (
      wr_evt_o.valid |-> wr_evt_o.data == $past(pins_i.data, 3))
      else $error("write data wrong");
   chk_wr_addr: assert property (
      wr_evt_o.valid && $past(pins_i.ale, 3) && $past(pins_i.ale, 4)
      |-> wr_evt_o.addr == $past(pins_i.addr, 3))
      else $error("write address wrong");
   chk_oe_read: assert property (
      data_oe_o == $past(rd_s, 3)) else $error("bus enable wrong");
   chk_bus_idle: assert property (
      !data_oe_o |-> data_o == 8'h00) else $error("idle bus not zero");
   chk_cs_sticky: assert property (
      cs_released_o |=> cs_released_o) else $error("cs flag dropped");
   chk_arst_hold: assert property (disable iff (srst_i)
      !async_reset_low_i |-> in_reset_o && !data_oe_o && !wr_evt_o.valid)
      else $error("pin reset not applied");
   chk_arst_free: assert property (disable iff (srst_i)
      $rose(async_reset_low_i) |-> in_reset_o ##1 in_reset_o ##1 !in_reset_o)
      else $error("reset release timing wrong");
   cov_write: cover property (wr_evt_o.valid);
   cov_read: cover property ($rose(data_oe_o));
   cov_rst: cover property (disable iff (srst_i) $fell(in_reset_o));
endmodule
bind hrw_port hrw_port_checker #(.NREGS(NREGS)) hrw_port_checker_i (
   .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
   .async_reset_low_i(async_reset_low_i), .pins_i(pins_i),
   .data_o(data_o), .data_oe_o(data_oe_o), .user_addr_i(user_addr_i),
   .user_data_o(user_data_o), .wr_evt_o(wr_evt_o),
   .in_reset_o(in_reset_o), .cs_released_o(cs_released_o));

/* hrw_host_model.sv */
// Host processor model driving the register port pins.
// Assumes its tasks are called from the bench on a running clock.
`timescale 1ns/1ps
module hrw_host_model (
   input wire logic clk_i,
   input wire logic [7:0] dev_data_i,
   input wire logic dev_oe_i,
   output hrw_pkg::hrw_pins_t pins_o
);
   hrw_pkg::hrw_pins_t p_r = hrw_pkg::PINS_IDLE;
   logic [7:0] hd_r = 8'h00;
   logic drv_r = 1'b0;
   // Released bus shows the inverse of the last value
   always_comb begin
      pins_o = p_r;
      pins_o.data = dev_oe_i ? dev_data_i : (drv_r ? hd_r : ~hd_r);
   end
   task automatic wr(input logic [7:0] a, d, input logic cs_first);
      @(posedge clk_i);
      p_r.addr <= a;
      hd_r <= d;
      drv_r <= 1'b1;
      p_r.chip_select_low <= 1'b0;
      p_r.write_strobe_low <= 1'b0;
      repeat (4) @(posedge clk_i);
      if (cs_first) p_r.chip_select_low <= 1'b1;
      else p_r.write_strobe_low <= 1'b1;
      repeat (2) @(posedge clk_i);
      p_r.chip_select_low <= 1'b1;
      p_r.write_strobe_low <= 1'b1;
      drv_r <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic cyc(input logic [7:0] a, input logic c, w, r,
      output logic oe, output logic [7:0] q);
      @(posedge clk_i);
      p_r.addr <= a;
      p_r.chip_select_low <= c;
      p_r.write_strobe_low <= w;
      p_r.read_strobe_low <= r;
      repeat (6) @(posedge clk_i);
      oe = dev_oe_i;
      q = pins_o.data;
      p_r.chip_select_low <= 1'b1;
      p_r.write_strobe_low <= 1'b1;
      p_r.read_strobe_low <= 1'b1;
      repeat (5) @(posedge clk_i);
   endtask
   task automatic ale_set(input logic v);
      @(posedge clk_i);
      p_r.ale <= v;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

/* tb_top.sv */
// Self-checking bench of the host register port with a host model.
// Assumes a 250 MHz core clock; the model drives every host pin.
`timescale 1ns/1ps
`define CHK(a, b) begin \
   n_checks++; \
   if ((a) !== (b)) begin \
      errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
   end \
end
module tb_top;
   localparam int NR = 16;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_i = 1'b1;
   logic arst_low = 1'b0;
   logic [7:0] ua = 8'h00;
   hrw_pkg::hrw_pins_t pins;
   logic [7:0] dout, ud, q_s;
   logic oe, in_rst, cs_rel, oe_s;
   hrw_pkg::hrw_wr_t evt, last_evt;
   int errors = 0;
   int n_checks = 0;
   int n_wr = 0;
   hrw_port #(.NREGS(NR)) hrw_port_i (.clk_i(clk_i), .srst_i(srst_i),
      .ce_i(ce_i), .async_reset_low_i(arst_low), .pins_i(pins),
      .data_o(dout), .data_oe_o(oe), .user_addr_i(ua), .user_data_o(ud),
      .wr_evt_o(evt), .in_reset_o(in_rst), .cs_released_o(cs_rel));
   hrw_host_model hrw_host_model_i (.clk_i(clk_i), .dev_data_i(dout),
      .dev_oe_i(oe), .pins_o(pins));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   always @(negedge clk_i) begin
      if (evt.valid === 1'b1) begin
         n_wr++;
         last_evt = evt;
      end
   end
   task automatic test_done();
      $display("errors=%0d checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rd_user(input logic [7:0] a, exp);
      @(posedge clk_i);
      ua <= a;
      repeat (2) @(posedge clk_i);
      `CHK(ud, exp)
   endtask
   task automatic rd_host(input logic [7:0] a, exp);
      hrw_host_model_i.cyc(a, 1'b0, 1'b1, 1'b0, oe_s, q_s);
      `CHK(oe_s, 1'b1)
      `CHK(q_s, exp)
   endtask
   task automatic t_reset();
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      arst_low <= 1'b1;
      repeat (8) @(posedge clk_i);
      `CHK(in_rst, 1'b0)
      `CHK(oe, 1'b0)
      `CHK(cs_rel, 1'b1)
      rd_user(8'h00, 8'h00);
   endtask
   task automatic t_write();
      logic [7:0] al[3] = '{8'h00, 8'h0f, 8'h03};
      for (int i = 0; i < 3; i++) begin
         hrw_host_model_i.wr(al[i], al[i] ^ 8'h5a, 1'b0);
         `CHK(last_evt.addr, al[i])
         `CHK(last_evt.data, al[i] ^ 8'h5a)
         rd_host(al[i], al[i] ^ 8'h5a);
      end
      rd_user(8'h01, 8'h00);
      hrw_host_model_i.wr(8'h10, 8'h77, 1'b0);
      rd_user(8'h00, 8'h5a);
      rd_user(8'h10, 8'h00);
   endtask
   task automatic t_cs_first();
      hrw_host_model_i.wr(8'h02, 8'hc3, 1'b1);
      rd_user(8'h02, 8'hc3);
   endtask
   task automatic t_refuse();
      int k;
      k = n_wr;
      hrw_host_model_i.cyc(8'h02, 1'b0, 1'b1, 1'b1, oe_s, q_s);
      `CHK(oe_s, 1'b0)
      hrw_host_model_i.cyc(8'h02, 1'b1, 1'b0, 1'b1, oe_s, q_s);
      hrw_host_model_i.cyc(8'h02, 1'b1, 1'b1, 1'b0, oe_s, q_s);
      `CHK(oe_s, 1'b0)
      `CHK(n_wr, k)
      rd_user(8'h02, 8'hc3);
   endtask
   task automatic t_ale();
      hrw_host_model_i.cyc(8'h05, 1'b1, 1'b1, 1'b1, oe_s, q_s);
      hrw_host_model_i.ale_set(1'b0);
      hrw_host_model_i.wr(8'h09, 8'h3c, 1'b0);
      `CHK(last_evt.addr, 8'h05)
      hrw_host_model_i.ale_set(1'b1);
      rd_user(8'h05, 8'h3c);
      rd_user(8'h09, 8'h00);
   endtask
   task automatic t_hold();
      @(posedge clk_i);
      ce_i <= 1'b0;
      ua <= 8'h05;
      repeat (3) @(posedge clk_i);
      `CHK(ud, 8'h00)
      ce_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK(ud, 8'h3c)
   endtask
   task automatic t_async();
      @(posedge clk_i);
      arst_low <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK(in_rst, 1'b1)
      arst_low <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd_user(8'h05, 8'h00);
      rd_user(8'h02, 8'h00);
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      test_done();
   end
   initial begin
      t_reset();
      t_write();
      t_cs_first();
      t_refuse();
      t_ale();
      t_hold();
      t_async();
      test_done();
   end
endmodule
